// [core/exec_subset_regs.svh]
/*
 * register offsets, opcodes, field positions and fixed figures
 * for the instruction execute slice; included by the core
 */
`ifndef EXEC_SUBSET_REGS_SVH
`define EXEC_SUBSET_REGS_SVH
// ****************************************
// register map (byte addresses)
// ****************************************
`define OFS_CMD      8'h00
`define OFS_SRC1     8'h04
`define OFS_SRC2     8'h08
`define OFS_EA       8'h0C
`define OFS_RESULT   8'h10
`define OFS_STATUS   8'h14
`define OFS_REGBASE  8'h40
// command fields
`define CMD_DMODE_LO 16
`define CMD_N_LO     20
// destination/source addressing classes
`define MODE_PLAIN   3'h0
`define MODE_LIT     3'h1
`define MODE_IMM     3'h2
`define MODE_REG     3'h3
`define MODE_EXP     3'h4
// general register indices
`define R_FP         4'h9
`define R_AP         4'hA
`define R_SP         4'hC
`define R_PC         4'hF
// ****************************************
// opcodes and fixed figures
// ****************************************
`define OP_BLKMOVE   16'h3019
`define OP_VERSION   16'h3009
`define OP_NOP1      16'h0070
`define OP_NO_OPERATION_TWO_BYTE      16'h0073
`define OP_NO_OPERATION_THREE_BYTE      16'h0072
`define OP_POP_WORD      16'h0020
`define OP_PUSHA     16'h00E0
`define OP_PUSH_WORD     16'h00A0
`define OP_RCC       16'h0050
`define OP_RCS       16'h0058
`define OP_RETURN_IF_EQUAL_SIGNED      16'h007C
`define OP_RETURN_IF_EQUAL_UNSIGNED     16'h006C
`define OP_RETURN_IF_GREATER_EQUAL_SIGNED      16'h0040
`define OP_RETURN_IF_GREATER_SIGNED      16'h0044
`define OP_RESTORE   16'h0018
`define WORD_STEP    32'h0000_0004
`define FRAME_LINK   32'h0000_001C
`define FRAME_REGS   32'h0000_0018
`define RETP_PC_OFS  32'h0000_0008
`endif

// [core/exec_subset_pkg.sv]
/*
 * types for the instruction execute slice
 * assumes exec_subset_regs.svh is on the include path
 */
package exec_subset_pkg;
  typedef enum logic [3:0] {
    IDLE, EXEC, MV_RD, MV_WR, POP_RD, PUSH_WR, RET_RD, RST_FP, RST_RG, RP_AP, RP_PC
  } state_t;
  typedef struct packed {
    state_t           st;
    logic [15:0][31:0] regs;
    logic [15:0]      opc;
    logic [2:0]       dmode;
    logic [3:0]       nsel;
    logic [31:0]      src1, src2, ea, result, tmpB;
    logic [3:0]       nzcv;
    logic             busy, done, illegal, intOvf, fault, intr, irqTaken;
    logic             memReq, memWe;
    logic [31:0]      memAddr, memWdata, prdata;
    logic             pready, pslverr;
  } ctx_t;
endpackage

// [core/exec_subset.sv]
/*
 * execute slice: block word move, multiply, version, no-ops, or,
 * push/pop, conditional returns, register restore, procedure return.
 * assumes an apb master on one mclk and a word memory answering
 * memReq with a one-cycle memAck (memFault valid with it).
 */
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "exec_subset_regs.svh"

// Summary of operation
// - block move takes interrupts between iterations only
// - move leaves registers unchanged on a faulting access
// - copy word, pointers plus 4, count minus 1
// - stop at zero count; zero moves nothing
// - two-operand multiply, byte half word opcodes
// - three-operand multiply into destination
// - multiply flags, overflow exception on truncation
// - literal or immediate destination is illegal
// - version into r0, flags unchanged
// - no-ops advance by length only
// - two-operand or with flags
// - three-operand or, same flags
// - pop word, flags, illegal destination modes
// - push effective address, illegal source modes
// - push word, flags, expanded type faults
// - return on carry clear or set
// - both equal returns test zero
// - signed greater-equal and greater returns
// - restore registers and frame from frame
// - procedure return reloads ap, pc, sp
module exec_subset #(
  parameter logic [7:0]  VERSION = 8'h01,  // arbitrary value
  parameter logic [15:0] OP_RETP = 16'h0008
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irqReq,
  output logic             irqTaken,
  output logic             memReq,
  output logic             memWe,
  output logic      [31:0] memAddr,
  output logic      [31:0] memWdata,
  input  wire logic [31:0] memRdata,
  input  wire logic        memAck,
  input  wire logic        memFault
);
  import exec_subset_pkg::*;

  ctx_t q, d;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [1:0] opSize(input logic [15:0] op);
    case (op[1:0])
      2'h3:    opSize = 2'h0;
      2'h2:    opSize = 2'h1;
      default: opSize = 2'h2;
    endcase
  endfunction

  function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      2'h0:    sext = {{24{v[7]}}, v[7:0]};
      2'h1:    sext = {{16{v[15]}}, v[15:0]};
      default: sext = v;
    endcase
  endfunction

  function automatic logic [31:0] zmask(input logic [1:0] sz);
    case (sz)
      2'h0:    zmask = 32'h0000_00FF;
      2'h1:    zmask = 32'h0000_FFFF;
      default: zmask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFS_STATUS || a[7:6] == 2'h1);
  endfunction

  logic [1:0]         sz;
  logic signed [63:0] prod;
  logic [31:0]        mulR, orW, orR;
  logic               mulTrunc, isMul, isOr, three, dstBad, retOp, retCond, isMove;

  // operand arithmetic used by the decode in the EXEC state
  always_comb begin
    sz       = opSize(q.opc);
    prod     = 64'($signed(sext(three ? q.src1 : q.src2, sz)))
             * 64'($signed(sext(three ? q.src2 : q.src1, sz)));  // full signed product
    mulR     = sext(prod[31:0], sz);
    mulTrunc = {{32{mulR[31]}}, mulR} != prod;  // truncated when it no longer sign-extends
    orW      = q.src1 | q.src2;
    orR      = orW & zmask(sz);
  end

  // opcode classes
  assign isMul   = q.opc[15:8] == 8'h00 && (q.opc[7:5] == 3'h5 || q.opc[7:5] == 3'h7)
                 && q.opc[4:2] == 3'h2;
  assign isOr    = q.opc[15:8] == 8'h00 && (q.opc[7:4] == 4'hB || q.opc[7:4] == 4'hF)
                 && q.opc[3:2] == 2'h0;
  assign three   = q.opc[6];
  assign dstBad  = q.dmode == `MODE_LIT || q.dmode == `MODE_IMM;
  assign isMove  = q.opc == `OP_BLKMOVE;
  assign retOp   = q.opc == `OP_RCC || q.opc == `OP_RCS || q.opc == `OP_RETURN_IF_EQUAL_SIGNED
                 || q.opc == `OP_RETURN_IF_EQUAL_UNSIGNED || q.opc == `OP_RETURN_IF_GREATER_EQUAL_SIGNED || q.opc == `OP_RETURN_IF_GREATER_SIGNED;

  // return conditions on n z c v = nzcv[3:0]
  always_comb begin
    case (q.opc)
      `OP_RCC:             retCond = ~q.nzcv[1];
      `OP_RCS:             retCond = q.nzcv[1];
      `OP_RETURN_IF_EQUAL_SIGNED, `OP_RETURN_IF_EQUAL_UNSIGNED: retCond = q.nzcv[2];
      `OP_RETURN_IF_GREATER_EQUAL_SIGNED:            retCond = ~q.nzcv[3] | q.nzcv[2];
      `OP_RETURN_IF_GREATER_SIGNED:            retCond = ~(q.nzcv[3] | q.nzcv[2]);
      default:             retCond = 1'b0;
    endcase
  end

  // ****************************************
  // next-state logic: bus slave and sequencer
  // ****************************************
  always_comb begin
    d          = q;
    d.irqTaken = 1'b0;
    d.pready   = psel & penable & ~q.pready;  // one wait state per access
    d.pslverr  = 1'b0;
    d.prdata   = 32'h0000_0000;
    if (psel & penable & ~q.pready) begin
      d.pslverr = ~mapped(paddr);
      case (paddr)
        `OFS_CMD:    d.prdata = {8'h00, q.nsel, 1'b0, q.dmode, q.opc};
        `OFS_SRC1:   d.prdata = q.src1;
        `OFS_SRC2:   d.prdata = q.src2;
        `OFS_EA:     d.prdata = q.ea;
        `OFS_RESULT: d.prdata = q.result;
        `OFS_STATUS: d.prdata = {20'h0, q.nzcv, 2'h0, q.intr, q.fault, q.intOvf,
                                 q.illegal, q.done, q.busy};
        default:     d.prdata = mapped(paddr) ? q.regs[paddr[5:2]] : 32'h0;
      endcase
    end
    // writes land at the edge that completes the access; ignored while busy
    if (psel & penable & q.pready & pwrite & mapped(paddr) & ~q.busy) begin
      case (paddr)
        `OFS_CMD: begin
          d.opc     = pwdata[15:0];
          d.dmode   = pwdata[`CMD_DMODE_LO +: 3];
          d.nsel    = pwdata[`CMD_N_LO +: 4] > `R_FP ? `R_FP : pwdata[`CMD_N_LO +: 4];
          d.busy    = 1'b1;
          d.done    = 1'b0;
          d.illegal = 1'b0;
          d.intOvf  = 1'b0;
          d.fault   = 1'b0;
          d.intr    = 1'b0;
          d.st      = EXEC;
        end
        `OFS_SRC1:   d.src1 = pwdata;
        `OFS_SRC2:   d.src2 = pwdata;
        `OFS_EA:     d.ea = pwdata;
        `OFS_STATUS: d.nzcv = pwdata[11:8];
        `OFS_RESULT: d.result = pwdata;
        default:     d.regs[paddr[5:2]] = pwdata;
      endcase
    end
    // a memory access completes on memAck; drop the request then
    if (memAck) d.memReq = 1'b0;
    case (q.st)
      IDLE: ;
      EXEC: begin
        d.st   = IDLE;
        d.busy = 1'b0;
        d.done = 1'b1;
        if (isMove) begin
          if (q.regs[2] != 32'h0 && irqReq) begin
            d.intr     = 1'b1;
            d.irqTaken = 1'b1;
          end else if (q.regs[2] != 32'h0) begin
            d.st      = MV_RD;
            d.busy    = 1'b1;
            d.done    = 1'b0;
            d.memReq  = 1'b1;
            d.memWe   = 1'b0;
            d.memAddr = q.regs[0];
          end
        end else if ((isMul | isOr) & dstBad) begin
          d.illegal = 1'b1;
        end else if (isMul) begin
          d.result = mulR & zmask(sz);
          d.nzcv   = {prod < 0, prod == 0, 1'b0, mulTrunc};
          d.intOvf = mulTrunc;
        end else if (isOr) begin
          d.result = orR;
          d.nzcv   = {orR[sz == 2'h0 ? 5'd7 : sz == 2'h1 ? 5'd15 : 5'd31],
                      orR == 32'h0, 1'b0, orW != orR};
        end else if (q.opc == `OP_VERSION) begin
          d.regs[0] = {{24{VERSION[7]}}, VERSION};
        end else if (q.opc == `OP_NOP1 || q.opc == `OP_NO_OPERATION_TWO_BYTE || q.opc == `OP_NO_OPERATION_THREE_BYTE) begin
          d.regs[`R_PC] = q.regs[`R_PC] + (q.opc == `OP_NOP1 ? 32'h1
                        : q.opc == `OP_NO_OPERATION_TWO_BYTE ? 32'h2 : 32'h3);
        end else if (q.opc == `OP_POP_WORD) begin
          if (dstBad || q.dmode == `MODE_EXP) d.illegal = 1'b1;
          else begin
            d.st = POP_RD;
            d.busy = 1'b1;
            d.done = 1'b0;
            d.memReq = 1'b1;
            d.memWe = 1'b0;
            d.memAddr = q.regs[`R_SP] - `WORD_STEP;
          end
        end else if (q.opc == `OP_PUSHA || q.opc == `OP_PUSH_WORD) begin
          if ((q.opc == `OP_PUSHA && (dstBad || q.dmode == `MODE_REG))
              || q.dmode == `MODE_EXP) d.illegal = 1'b1;
          else begin
            d.st       = PUSH_WR;
            d.busy     = 1'b1;
            d.done     = 1'b0;
            d.memReq   = 1'b1;
            d.memWe    = 1'b1;
            d.memAddr  = q.regs[`R_SP];
            d.memWdata = q.opc == `OP_PUSHA ? q.ea : q.src1;
          end
        end else if (retOp) begin
          if (retCond) begin
            d.st = RET_RD;
            d.busy = 1'b1;
            d.done = 1'b0;
            d.memReq = 1'b1;
            d.memWe = 1'b0;
            d.memAddr = q.regs[`R_SP] - `WORD_STEP;
          end else d.regs[`R_PC] = q.regs[`R_PC] + 32'h1;
        end else if (q.opc == `OP_RESTORE || q.opc == OP_RETP) begin
          d.st      = q.opc == `OP_RESTORE ? RST_FP : RP_AP;
          d.busy    = 1'b1;
          d.done    = 1'b0;
          d.memReq  = 1'b1;
          d.memWe   = 1'b0;
          d.memAddr = q.opc == `OP_RESTORE ? q.regs[`R_FP] - `FRAME_LINK
                                           : q.regs[`R_SP] - `WORD_STEP;
        end
      end
      default: begin
        // every other state waits on one memory access
        if (memAck && memFault) begin
          d.fault = 1'b1;  // registers stay as they were, so a rerun resumes
          d.st    = IDLE;
          d.busy  = 1'b0;
          d.done  = 1'b1;
        end else if (memAck) begin
          d.st = EXEC;
          case (q.st)
            MV_RD: begin
              d.st       = MV_WR;
              d.memReq   = 1'b1;
              d.memWe    = 1'b1;
              d.memAddr  = q.regs[1];
              d.memWdata = memRdata;
            end
            MV_WR: begin
              d.regs[0] = q.regs[0] + `WORD_STEP;
              d.regs[1] = q.regs[1] + `WORD_STEP;
              d.regs[2] = q.regs[2] - 32'h1;
            end
            POP_RD: begin
              d.result      = memRdata;
              d.regs[`R_SP] = q.regs[`R_SP] - `WORD_STEP;
              d.nzcv        = {memRdata[31], memRdata == 32'h0, 2'h0};
              d.opc         = 16'h0000;
            end
            PUSH_WR: begin
              d.regs[`R_SP] = q.regs[`R_SP] + `WORD_STEP;
              d.nzcv        = {q.memWdata[31], q.memWdata == 32'h0, 2'h0};
              d.opc         = 16'h0000;
            end
            RET_RD: begin
              d.regs[`R_PC] = memRdata;
              d.regs[`R_SP] = q.regs[`R_SP] - `WORD_STEP;
              d.opc         = 16'h0000;
            end
            RST_FP, RST_RG: begin
              if (q.st == RST_FP) d.tmpB = memRdata;  // saved frame link
              else begin
                d.regs[q.nsel] = memRdata;
                d.nsel         = q.nsel + 4'h1;
              end
              if ((q.st == RST_FP ? q.nsel : q.nsel + 4'h1) == `R_FP) begin
                d.regs[`R_FP] = q.st == RST_FP ? memRdata : q.tmpB;
                d.regs[`R_SP] = q.regs[`R_FP] - `FRAME_LINK;
                d.opc         = 16'h0000;
              end else begin
                d.st      = RST_RG;
                d.memReq  = 1'b1;
                d.memAddr = q.st == RST_FP ? q.regs[`R_FP] - `FRAME_REGS
                                           : q.memAddr + `WORD_STEP;
              end
            end
            RP_AP: begin
              d.tmpB    = memRdata;
              d.st      = RP_PC;
              d.memReq  = 1'b1;
              d.memAddr = q.regs[`R_SP] - `RETP_PC_OFS;
            end
            RP_PC: begin
              d.regs[`R_PC] = memRdata;
              d.regs[`R_AP] = q.tmpB;
              d.regs[`R_SP] = q.regs[`R_AP];
              d.opc         = 16'h0000;
            end
            default: d.st = IDLE;
          endcase
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (rst) q <= '0;
    else q <= d;
  end

  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign irqTaken = q.irqTaken;
  assign memReq   = q.memReq;
  assign memWe    = q.memWe;
  assign memAddr  = q.memAddr;
  assign memWdata = q.memWdata;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_irq_boundary: assert property (q.irqTaken |-> $past(q.st) == EXEC && !q.memReq)
    else $error("interrupt taken inside an iteration");
  chk_fault_hold: assert property (q.st == MV_WR && memAck && memFault |=>
    q.regs[2] == $past(q.regs[2]) && q.fault) else $error("count moved on fault");
  chk_move_step: assert property (q.st == MV_WR && memAck && !memFault |=>
    q.regs[1] == $past(q.regs[1]) + 32'h4 && q.regs[2] == $past(q.regs[2]) - 32'h1)
    else $error("bad move step");
  chk_zero_count: assert property (q.st == EXEC && isMove && q.regs[2] == 32'h0 |=>
    !q.busy && !q.memReq) else $error("zero count moved data");
  chk_mul_flags: assert property (q.st == EXEC && isMul && !dstBad |=>
    !q.nzcv[1] && q.intOvf == q.nzcv[0]) else $error("multiply flags wrong");
  chk_bad_dst: assert property (q.st == EXEC && (isMul || isOr) && dstBad |=>
    q.illegal && $stable(q.result)) else $error("illegal destination written");
  chk_version_load: assert property (q.st == EXEC && q.opc == `OP_VERSION |=>
    $signed(q.regs[0]) == $signed(VERSION) && $stable(q.nzcv)) else $error("version bad");
  chk_ret_false: assert property (q.st == EXEC && retOp && !retCond |=>
    $stable(q.regs[`R_SP]) && q.regs[`R_PC] == $past(q.regs[`R_PC]) + 32'h1)
    else $error("false return changed state");

  cov_move_iter: cover property (q.st == MV_WR && memAck && !memFault);
  cov_move_irq: cover property (q.irqTaken);
  cov_restore: cover property (q.st == RST_RG && memAck);
endmodule

// [verification/word_memory.sv]
/*
 * word memory standing for system memory behind the execute slice.
 * assumes one outstanding word request, held until memAck.
 */
`timescale 1ns/1ps
module word_memory (
  input  wire logic        mclk,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic      [31:0] memRdata,
  output logic             memAck,
  output logic             memFault,
  input  wire logic [3:0]  lag,
  input  wire logic        faultOn,
  input  wire logic [31:0] faultAddr
);
  // ****************
  // storage and answer
  // ****************
  logic [31:0] words [64];
  logic [31:0] lastQ   = 32'h0;
  logic [3:0]  waitCnt = 4'h0;
  logic        hit;
  assign hit = faultOn && memAddr == faultAddr;
  // answer after lag idle cycles; a faulting write leaves the word alone
  always @(posedge mclk) begin
    memAck <= 1'b0;
    memFault <= 1'b0;
    if (memReq && !memAck) begin
      waitCnt <= waitCnt + 4'h1;
      if (waitCnt >= lag) begin
        waitCnt <= 4'h0;
        memAck <= 1'b1;
        memFault <= hit;
        if (!memWe) lastQ <= words[memAddr[7:2]];
        else if (!hit) words[memAddr[7:2]] <= memWdata;
      end
    end
  end
  // outside the answer cycle show the inverse, so a late sample never passes
  assign memRdata = memAck ? lastQ : ~lastQ;
endmodule

// [verification/cpu_instruction_execute_subset_tb.sv]
/*
 * bench for the execute slice: apb register traffic, a table of alu cases,
 * then version, no-op, return, stack, move and frame cases by hand.
 * assumes word_memory answers the memory port.
 */
`timescale 1ns/1ps
module cpu_instruction_execute_subset_tb;
  // ****************
  // signals and tables
  // ****************
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, irqReq, irqTaken;
  logic        memReq, memWe, memAck, memFault, faultOn, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, memAddr, memWdata, memRdata, faultAddr, q, st, t;
  logic [3:0]  lag;
  int          failures = 0, total_checks = 0, irqSeen = 0;
  typedef struct packed { logic [31:0] cmd, s1, s2, res, st, mask; } alu_row_t;
  typedef struct packed { logic [15:0] op; logic [3:0] f; logic tk; } ret_row_t;
  alu_row_t aluRows [13] = '{
    '{32'hA8, 32'h3, 32'h5, 32'hF, 32'h2, 32'hF0E},
    '{32'hAB, 32'h10, 32'h10, 32'h0, 32'h10A, 32'hF0E},
    '{32'hAA, 32'h10, 32'h20, 32'h200, 32'h2, 32'hF0E},
    '{32'hEB, 32'h2, 32'h3, 32'h6, 32'h2, 32'hF0E},
    '{32'hEA, 32'h100, 32'h10, 32'h1000, 32'h2, 32'hF0E},
    '{32'hE8, 32'h0, 32'h7, 32'h0, 32'h402, 32'hF0E},
    '{32'hB0, 32'h1, 32'h8000_0000, 32'h8000_0001, 32'h802, 32'hF06},
    '{32'hB3, 32'h1, 32'h2, 32'h3, 32'h2, 32'hF06},
    '{32'hB2, 32'h12, 32'h10000, 32'h12, 32'h102, 32'hF06},
    '{32'hF3, 32'h80, 32'h1, 32'h81, 32'h802, 32'hF06},
    '{32'hF2, 32'h0, 32'h0, 32'h0, 32'h402, 32'hF06},
    '{32'h100A8, 32'h1, 32'h1, 32'h0, 32'h4, 32'h4},
    '{32'h200F0, 32'h1, 32'h1, 32'h0, 32'h4, 32'h4}};
  ret_row_t retRows [11] = '{'{16'h50, 4'h0, 1'b1}, '{16'h50, 4'h2, 1'b0},
    '{16'h58, 4'h2, 1'b1}, '{16'h58, 4'h0, 1'b0}, '{16'h7C, 4'h4, 1'b1},
    '{16'h6C, 4'h0, 1'b0}, '{16'h40, 4'h8, 1'b0}, '{16'h40, 4'hC, 1'b1},
    '{16'h44, 4'h0, 1'b1}, '{16'h44, 4'h4, 1'b0}, '{16'h6C, 4'h4, 1'b1}};
  logic [31:0] badOp [6] = '{32'h100E0, 32'h300E0, 32'h400E0, 32'h20020, 32'h40020, 32'h400A0};
  logic [31:0] nopOp [3] = '{32'h70, 32'h73, 32'h72};
  logic [31:0] nopSum [3] = '{32'h1, 32'h3, 32'h6};
  logic [31:0] mvData [3] = '{32'h5, 32'h10, 32'h20};

  // version value is arbitrary; negative so sign extension shows
  exec_subset #(.VERSION(8'hF6)) uut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irqReq(irqReq), .irqTaken(irqTaken),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .memFault(memFault));
  word_memory mem (.mclk(mclk), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .memFault(memFault),
    .lag(lag), .faultOn(faultOn), .faultAddr(faultAddr));

  // ****************
  // clock, monitors, tasks
  // ****************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (irqTaken === 1'b1) irqSeen++;
  // watchdog well beyond the thousand or so cycles the run needs
  initial begin
    #2000000;
    failures++;
    tally_and_finish();
  end
  function automatic logic [7:0] rg(input int i);
    return 8'h40 + 8'(4 * i);
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer: setup, access held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no local limit: a stuck access is ended by the watchdog
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // start a command and poll busy; a stuck busy counts as a mismatch
  task run(input logic [31:0] cmd);
    wr(8'h00, cmd);
    do begin
      apb(1'b0, 8'h14, 32'h0);
    end while (q[0] !== 1'b0);
    st = q;
  endtask
  task mvSetup(input logic [31:0] n);
    for (int k = 0; k < 3; k++) begin
      mem.words[4 + k] = mvData[k];
      mem.words[12 + k] = 32'h0;
    end
    wr(rg(0), 32'h10);
    wr(rg(1), 32'h30);
    wr(rg(2), n);
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    {rst, psel, penable, pwrite, irqReq, faultOn} = 6'h20;
    {paddr, pwdata, faultAddr, lag} = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h14, 32'h0);
    chk({31'h0, err}, 32'h0);
    rd(rg(5), 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    // just past the last general register: must not alias register 0
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset and map test finished");
    foreach (aluRows[i]) begin
      wr(8'h04, aluRows[i].s1);
      wr(8'h08, aluRows[i].s2);
      run(aluRows[i].cmd);
      if (aluRows[i].mask != 32'h4)
        rd(8'h10, aluRows[i].res);
      chk(st & aluRows[i].mask, aluRows[i].st);
    end
    $display("alu table finished");
    wr(8'h14, 32'hF00);
    run(32'h3009);
    rd(rg(0), 32'hFFFF_FFF6);
    chk(st & 32'hF00, 32'hF00);
    wr(rg(15), 32'h100);
    for (int k = 0; k < 3; k++) begin
      run(nopOp[k]);
      rd(rg(15), 32'h100 + nopSum[k]);
      chk(st & 32'hF00, 32'hF00);
    end
    foreach (retRows[i]) begin
      wr(rg(12), 32'h84);
      wr(rg(15), 32'h10);
      mem.words[32] = 32'h5000;
      wr(8'h14, {20'h0, retRows[i].f, 8'h0});
      run({16'h0, retRows[i].op});
      rd(rg(15), retRows[i].tk ? 32'h5000 : 32'h11);
      rd(rg(12), retRows[i].tk ? 32'h80 : 32'h84);
      chk(st & 32'hF00, {20'h0, retRows[i].f, 8'h0});
    end
    $display("version, no-op and return tests finished");
    wr(rg(12), 32'h40);
    wr(8'h04, 32'h8000_0000);
    run(32'hA0);
    chk(mem.words[16], 32'h8000_0000);
    rd(rg(12), 32'h44);
    chk(st & 32'hF00, 32'h800);
    wr(8'h14, 32'h300);
    run(32'h20);
    rd(8'h10, 32'h8000_0000);
    rd(rg(12), 32'h40);
    chk(st & 32'hF00, 32'h800);
    wr(8'h0C, 32'h1234);
    run(32'hE0);
    chk(mem.words[16], 32'h1234);
    foreach (badOp[i]) begin
      run(badOp[i]);
      chk(st & 32'h4, 32'h4);
    end
    rd(rg(12), 32'h44);
    $display("stack test finished");
    lag = 4'h2;
    mvSetup(32'h3);
    run(32'h3019);
    for (int k = 0; k < 3; k++) chk(mem.words[12 + k], mvData[k]);
    rd(rg(0), 32'h1C);
    rd(rg(1), 32'h3C);
    rd(rg(2), 32'h0);
    mvSetup(32'h0);
    run(32'h3019);
    chk(mem.words[12], 32'h0);
    rd(rg(0), 32'h10);
    faultAddr = 32'h34;
    faultOn = 1'b1;
    mvSetup(32'h3);
    run(32'h3019);
    chk(st & 32'h10, 32'h10);
    rd(rg(0), 32'h14);
    rd(rg(1), 32'h34);
    rd(rg(2), 32'h2);
    faultOn = 1'b0;
    run(32'h3019);
    rd(rg(2), 32'h0);
    chk(mem.words[14], 32'h20);
    irqReq <= 1'b1;
    mvSetup(32'h3);
    run(32'h3019);
    chk(st & 32'h20, 32'h20);
    chk(32'(irqSeen), 32'h1);
    apb(1'b0, rg(2), 32'h0);
    t = q;
    rd(rg(0), 32'h10 + 32'h4 * (32'h3 - t));
    irqReq <= 1'b0;
    run(32'h3019);
    rd(rg(2), 32'h0);
    rd(rg(1), 32'h3C);
    $display("block move test finished");
    wr(rg(9), 32'h60);
    // stack pointer away from its expected value so the restore must move it
    wr(rg(12), 32'h0);
    mem.words[17] = 32'h50;
    mem.words[18] = 32'hAA7;
    mem.words[19] = 32'hAA8;
    run(32'h0070_0018);
    rd(rg(7), 32'hAA7);
    rd(rg(8), 32'hAA8);
    rd(rg(9), 32'h50);
    rd(rg(12), 32'h44);
    wr(rg(12), 32'h70);
    wr(rg(10), 32'h90);
    mem.words[27] = 32'hA0;
    mem.words[26] = 32'h2222;
    run(32'h8);
    rd(rg(10), 32'hA0);
    rd(rg(15), 32'h2222);
    rd(rg(12), 32'h90);
    $display("frame test finished");
    // reset in the middle of a slow move: request, status and count all clear
    lag = 4'hF;
    mvSetup(32'h3);
    wr(8'h00, 32'h3019);
    repeat (4) @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk({31'h0, memReq}, 32'h0);
    rd(8'h14, 32'h0);
    rd(rg(2), 32'h0);
    $display("mid-run reset test finished");
    tally_and_finish();
  end
endmodule
